// ---- ssd_pkg.sv ----
package ssd_pkg;
  // chain geometry
  localparam int NUM_CH      = 64;
  localparam int CNT_W       = 7;
  localparam logic [CNT_W-1:0] FRAME_LEN = 7'h40;
  // buffer between pin sampling and the chain
  localparam int FIFO_DEPTH  = 8;
  // reset values
  localparam logic RST_BIT   = 1'h0;
  localparam logic [NUM_CH-1:0] RST_WORD = 64'h0000_0000_0000_0000;
  // open-drain pads only ever pull low
  localparam logic SINK_LEVEL = 1'h0;
  // master clock and the far side's shortest legal shift clock phase
  localparam int MCLK_PERIOD_NS = 5;
  localparam int SCLK_PHASE_NS  = 62;
  localparam int SCLK_PHASE_CYC = SCLK_PHASE_NS / MCLK_PERIOD_NS;

  // one serial bit as it travels through the buffer
  typedef struct packed {
    logic data;
  } ssd_bit_t;
endpackage

// ---- ssd_top.sv ----
// Contract
// - 64 shift stages, 64 latches, 64 outputs
// - falling shift clock advances chain, captures input
// - serial output mirrors last shift stage
// - shifting ignores latch, blank, polarity inputs
// - latch load high: latches follow stages
// - latch load low: latches hold values
// - blank low forces all outputs per polarity
// - polarity high: latch one sinks output
// - polarity low inverts output sense
// - variants differ only in ring direction
`timescale 1ns/1ps

// small synchronous fifo with valid/ready on both sides
module ssd_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 8
) (
  input  wire logic             i_mclk,
  input  wire logic             i_rst,
  input  wire logic             i_valid,
  output logic                  o_ready,
  input  wire logic [WIDTH-1:0] i_data,
  output logic                  o_valid,
  input  wire logic             i_ready,
  output logic [WIDTH-1:0]      o_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg  [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      wr_ptr_next;
  logic [AW:0]      rd_ptr_reg;
  logic [AW:0]      rd_ptr_next;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  // extra pointer bit tells full from empty without a counter
  assign full    = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                   (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign empty   = (wr_ptr_reg == rd_ptr_reg);
  assign o_ready = ~full;
  assign o_valid = ~empty;
  assign o_data  = mem_reg[rd_ptr_reg[AW-1:0]];
  assign push    = i_valid & ~full;
  assign pop     = ~empty & i_ready;

  // next pointers and storage
  always_comb
  begin
    mem_next    = mem_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    if (push)
    begin
      mem_next[wr_ptr_reg[AW-1:0]] = i_data;
      wr_ptr_next = wr_ptr_reg + 1'b1;
    end
    if (pop)
    begin
      rd_ptr_next = rd_ptr_reg + 1'b1;
    end
  end

  // storage is not reset; only the pointers define contents
  always_ff @(posedge i_mclk)
  begin
    mem_reg <= mem_next;
    if (i_rst)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
    end
  end
endmodule

// serial-in, latched, open-drain sink driver core
module ssd_top #(
  parameter int   NUM_CH     = ssd_pkg::NUM_CH,
  parameter int   FIFO_DEPTH = ssd_pkg::FIFO_DEPTH,
  parameter logic RING_CW    = 1'h0
) (
  input  wire logic              i_mclk,
  input  wire logic              i_rst,
  input  wire logic              i_shift_clk,
  input  wire logic              i_serial_in,
  input  wire logic              i_latch_load,
  input  wire logic              i_output_blank_n,
  input  wire logic              i_polarity_sel,
  input  wire logic              i_chain_hold,
  input  wire logic [NUM_CH-1:0] i_hv_sink_in,
  output logic       [NUM_CH-1:0] o_hv_sink_out,
  output logic       [NUM_CH-1:0] o_hv_sink_oe,
  output logic                    o_serial_out,
  output logic                    o_serial_ready,
  output logic                    o_frame_loaded,
  output logic                    o_sink_mismatch
);
  logic                     sclk_prev_reg;
  logic                     sclk_prev_next;
  logic                     sclk_fall;
  ssd_pkg::ssd_bit_t        in_bit;
  ssd_pkg::ssd_bit_t        buf_bit;
  logic                     buf_valid;
  logic                     buf_ready;
  logic                     chain_step;
  logic [NUM_CH-1:0]        chain_reg;
  logic [NUM_CH-1:0]        chain_next;
  logic [NUM_CH-1:0]        latch_reg;
  logic [NUM_CH-1:0]        latch_next;
  logic                     serial_out_reg;
  logic                     serial_out_next;
  logic [ssd_pkg::CNT_W-1:0] shift_cnt_reg;
  logic [ssd_pkg::CNT_W-1:0] shift_cnt_next;
  logic                     loaded_reg;
  logic                     loaded_next;
  logic [NUM_CH-1:0]        sink_on;
  logic [NUM_CH-1:0]        oe_reg;
  logic [NUM_CH-1:0]        oe_next;
  logic                     mismatch_reg;
  logic                     mismatch_next;

  // edge detector next state; inputs are already synchronous, so one
  // sample of history is enough to see a fall
  always_comb
  begin
    sclk_prev_next = i_shift_clk;
  end

  // a reset value of 0 means a shift clock held low across release never
  // looks like a fall
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      sclk_prev_reg <= ssd_pkg::RST_BIT;
    end
    else
    begin
      sclk_prev_reg <= sclk_prev_next;
    end
  end

  // a fall is a high sample followed by a low level
  assign sclk_fall   = sclk_prev_reg & ~i_shift_clk;
  assign in_bit.data = i_serial_in;

  // the buffer absorbs bits while the chain is held; a fall that finds it
  // full is dropped, so a held chain loses data past the buffer depth
  ssd_fifo #(
    .WIDTH ($bits(ssd_pkg::ssd_bit_t)),
    .DEPTH (FIFO_DEPTH)
  ) ssd_fifo_inst (
    .i_mclk  (i_mclk),
    .i_rst   (i_rst),
    .i_valid (sclk_fall),
    .o_ready (buf_ready),
    .i_data  (in_bit),
    .o_valid (buf_valid),
    .i_ready (~i_chain_hold),
    .o_data  (buf_bit)
  );

  assign o_serial_ready = buf_ready;
  assign chain_step     = buf_valid & ~i_chain_hold;

  // chain and frame counter next state; latch, blank and polarity never
  // gate the chain
  always_comb
  begin
    chain_next     = chain_reg;
    shift_cnt_next = shift_cnt_reg;
    if (chain_step)
    begin
      chain_next = {chain_reg[NUM_CH-2:0], buf_bit.data};
      // the counter saturates so long streams cannot wrap it back to zero
      if (shift_cnt_reg != ssd_pkg::FRAME_LEN)
      begin
        shift_cnt_next = shift_cnt_reg + 1'h1;
      end
    end
    // cascade output moves on the same edge as the chain
    serial_out_next = chain_next[NUM_CH-1];
  end

  // chain registers
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      chain_reg      <= ssd_pkg::RST_WORD;
      serial_out_reg <= ssd_pkg::RST_BIT;
      shift_cnt_reg  <= '0;
    end
    else
    begin
      chain_reg      <= chain_next;
      serial_out_reg <= serial_out_next;
      shift_cnt_reg  <= shift_cnt_next;
    end
  end

  // latch and frame flag next state
  always_comb
  begin
    // transparent while load is high, held otherwise
    latch_next  = i_latch_load ? chain_reg : latch_reg;
    loaded_next = loaded_reg;
    // a whole frame shifted and then latched makes the outputs trustworthy;
    // the flag is sticky, so only reset clears it
    if (i_latch_load && (shift_cnt_reg == ssd_pkg::FRAME_LEN))
    begin
      loaded_next = 1'h1;
    end
  end

  // latch registers; zero start stands in for the undefined power-up state
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      latch_reg  <= ssd_pkg::RST_WORD;
      loaded_reg <= ssd_pkg::RST_BIT;
    end
    else
    begin
      latch_reg  <= latch_next;
      loaded_reg <= loaded_next;
    end
  end

  // output stage: each pad position picks a latch per ring direction
  genvar p;
  generate
    for (p = 0; p < NUM_CH; p++)
    begin : g_pad
      localparam int SRC = (RING_CW == 1'h1) ? (NUM_CH - 1 - p) : p;
      // blank low forces a common level; polarity picks sense
      assign sink_on[p] = i_output_blank_n
                          ? (i_polarity_sel ? latch_reg[SRC]
                                            : ~latch_reg[SRC])
                          : ~i_polarity_sel;
    end
  endgenerate

  // output stage next state: pads are only pulled low, so the enable is
  // the sink decision
  always_comb
  begin
    oe_next = sink_on;
  end

  // output registers; reset leaves every pad off
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      oe_reg <= ssd_pkg::RST_WORD;
    end
    else
    begin
      oe_reg <= oe_next;
    end
  end

  // readback next state: an enabled pad that still reads high points to a
  // fault; the flag lags the pads by one edge
  always_comb
  begin
    mismatch_next = |(oe_reg & i_hv_sink_in);
  end

  // readback register
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      mismatch_reg <= ssd_pkg::RST_BIT;
    end
    else
    begin
      mismatch_reg <= mismatch_next;
    end
  end

  assign o_hv_sink_oe    = oe_reg;
  assign o_hv_sink_out   = {NUM_CH{ssd_pkg::SINK_LEVEL}};
  assign o_serial_out    = serial_out_reg;
  assign o_frame_loaded  = loaded_reg;
  assign o_sink_mismatch = mismatch_reg;
endmodule

// ---- ssd_props.sv ----
`timescale 1ns/1ps
// watches the driver at its pins
module ssd_props #(
  parameter int NUM_CH = 64
) (
  input wire logic              i_mclk,
  input wire logic              i_rst,
  input wire logic              i_latch_load,
  input wire logic              i_output_blank_n,
  input wire logic              i_polarity_sel,
  input wire logic              i_chain_hold,
  input wire logic [NUM_CH-1:0] i_hv_sink_in,
  input wire logic [NUM_CH-1:0] o_hv_sink_out,
  input wire logic [NUM_CH-1:0] o_hv_sink_oe,
  input wire logic              o_serial_ready,
  input wire logic              o_frame_loaded,
  input wire logic              o_sink_mismatch
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // any enabled pad seen high
  logic pad_bad;
  assign pad_bad = |(o_hv_sink_oe & i_hv_sink_in);
  blank_force_a: assert property (
    !i_output_blank_n |=> o_hv_sink_oe == {NUM_CH{!$past(i_polarity_sel)}})
    else $error("blanked outputs off the common level");
  latch_hold_a: assert property (
    !i_latch_load && !$past(i_latch_load) && i_output_blank_n && $past(i_output_blank_n)
    && $stable(i_polarity_sel) && !$past(i_rst) |=> $stable(o_hv_sink_oe))
    else $error("outputs moved with latch closed");
  pol_flip_a: assert property (
    !i_latch_load && !$past(i_latch_load) && i_output_blank_n && $past(i_output_blank_n)
    && $changed(i_polarity_sel) && !$past(i_rst) |=> o_hv_sink_oe == ~$past(o_hv_sink_oe))
    else $error("polarity change did not invert outputs");
  pad_low_a: assert property (o_hv_sink_out == '0)
    else $error("open drain value not low");
  sink_check_a: assert property (
    !$past(i_rst) |-> o_sink_mismatch == $past(pad_bad))
    else $error("pad readback flag wrong");
  drain_ready_a: assert property ((!i_chain_hold)[*8] |-> o_serial_ready)
    else $error("buffer stays full while chain runs");
  frame_keep_a: assert property (o_frame_loaded |=> o_frame_loaded)
    else $error("frame flag dropped");
  frame_cause_a: assert property (
    $rose(o_frame_loaded) |-> $past(i_latch_load) || $past(i_latch_load, 2))
    else $error("frame flag without latch strobe");
  cover property (!i_output_blank_n && i_polarity_sel);
  cover property ($rose(o_frame_loaded));
  cover property (!o_serial_ready);
endmodule

bind ssd_top ssd_props #(.NUM_CH(NUM_CH)) ssd_props_inst (.i_mclk, .i_rst, .i_latch_load,
  .i_output_blank_n, .i_polarity_sel, .i_chain_hold, .i_hv_sink_in, .o_hv_sink_out,
  .o_hv_sink_oe, .o_serial_ready, .o_frame_loaded, .o_sink_mismatch);

// ---- ssd_ctrl.sv ----
`timescale 1ns/1ps
// controller side; shift clock idles high between frames
module ssd_ctrl (
  input  wire logic i_mclk,
  output logic      o_shift_clk,
  output logic      o_serial_in
);
  // one cycle over the minimum phase, since 12 cycles is only 60 ns
  localparam int PH = ssd_pkg::SCLK_PHASE_CYC + 1;
  // supply settling waits, one cycle over 100 ns and 200 ns
  localparam int SUPPLY_DN_CYC = 21;
  localparam int SUPPLY_UP_CYC = 41;
  // high-voltage supply as the controller switches it; starts grounded
  logic supply_on = 1'h0;
  initial
  begin
    o_shift_clk = 1'h1;
    o_serial_in = 1'h0;
  end
  // msb first so bit i ends in latch i; data set a phase before each fall
  task automatic send(input logic [63:0] w, input int n);
    for (int i = 63; i > 63 - n; i--)
    begin
      o_serial_in = w[i];
      repeat (PH) @(posedge i_mclk);
      #1 o_shift_clk = 1'h0;
      repeat (PH) @(posedge i_mclk);
      #1 o_shift_clk = 1'h1;
    end
    o_serial_in = ~o_serial_in; // hold time over: stale level is not kept
  endtask
  // ground the supply, then wait before touching any strobe
  task automatic power_down();
    supply_on = 1'h0;
    repeat (SUPPLY_DN_CYC) @(posedge i_mclk);
    #1;
  endtask
  // load, blank and polarity must have settled long before the rise
  task automatic power_up();
    repeat (SUPPLY_UP_CYC) @(posedge i_mclk);
    #1 supply_on = 1'h1;
  endtask
endmodule

// ---- ssd_top_bench.sv ----
`timescale 1ns/1ps
module ssd_top_bench;
  localparam logic [63:0] W1 = 64'hF00D_1234_8000_0001;
  localparam logic [63:0] W2 = 64'h0123_4567_89AB_CDEF;
  // W1 with its bit order reversed, as the other ring direction shows it
  localparam logic [63:0] W1_REV = 64'h8000_0001_2C48_B00F;
  logic        i_mclk = 1'h0, i_rst = 1'h1, load = 1'h0, blank_n = 1'h1;
  logic        polarity_sel = 1'h1, hold = 1'h0, fault = 1'h0, sclk, sdi, sdo, rdy, fl, mm;
  logic [63:0] oe, oe_cw, oe_seen = 64'h0;
  int          fails = 0, check_count = 0, cyc = 0;
  always #2.5 i_mclk = ~i_mclk;
  ssd_ctrl ssd_ctrl_inst (.i_mclk, .o_shift_clk(sclk), .o_serial_in(sdi));
  // pads pulled up: a sinking pad reads low unless a fault is injected
  ssd_top ssd_top_inst (.i_mclk, .i_rst, .i_shift_clk(sclk), .i_serial_in(sdi),
    .i_latch_load(load), .i_output_blank_n(blank_n), .i_polarity_sel(polarity_sel),
    .i_chain_hold(hold), .i_hv_sink_in(~oe | {64{fault}}), .o_hv_sink_out(),
    .o_hv_sink_oe(oe), .o_serial_out(sdo), .o_serial_ready(rdy), .o_frame_loaded(fl),
    .o_sink_mismatch(mm));
  // second copy wired the other way round the ring, same stimulus
  ssd_top #(.RING_CW(1'h1)) ssd_top_cw_inst (.i_mclk, .i_rst, .i_shift_clk(sclk),
    .i_serial_in(sdi), .i_latch_load(load), .i_output_blank_n(blank_n),
    .i_polarity_sel(polarity_sel), .i_chain_hold(hold), .i_hv_sink_in(~oe_cw | {64{fault}}),
    .o_hv_sink_out(), .o_hv_sink_oe(oe_cw), .o_serial_out(), .o_serial_ready(),
    .o_frame_loaded(), .o_sink_mismatch());
  // outputs may only switch while the high-voltage supply is grounded
  always @(posedge i_mclk)
  begin
    if (ssd_ctrl_inst.supply_on && (oe !== oe_seen))
      chk(oe, oe_seen);
    oe_seen <= oe;
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard, run needs about 4000 cycles
  always @(posedge i_mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      conclude();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  // frame loaded behind a closed latch, then strobed
  task automatic t_load();
    ssd_ctrl_inst.send(W1, 64);
    tick(3);
    chk(oe, 64'h0);
    chk(64'(fl), 64'h0);
    load = 1'h1; // raised long after the last fall
    tick(13);
    load = 1'h0; // 65 ns pulse
    tick(3);
    chk(oe, W1);
    chk(64'(fl), 64'h1);
    chk(oe_cw, W1_REV);
    chk(64'(sdo), 64'(W1[63]));
    $display("t_load done");
  endtask
  // polarity and blanking in every combination
  task automatic t_pol();
    polarity_sel = 1'h0;
    tick(2);
    chk(oe, ~W1);
    blank_n = 1'h0;
    tick(2);
    chk(oe, {64{1'h1}});
    polarity_sel = 1'h1;
    tick(2);
    chk(oe, 64'h0);
    blank_n = 1'h1;
    tick(2);
    chk(oe, W1);
    $display("t_pol done");
  endtask
  // shifting while blanked and transparent
  task automatic t_shift();
    blank_n = 1'h0;
    load = 1'h1;
    ssd_ctrl_inst.send(W2, 1);
    tick(3);
    chk(64'(sdo), 64'(W1[62]));
    ssd_ctrl_inst.send(W2 << 1, 63);
    tick(3);
    chk(64'(sdo), 64'(W2[63]));
    blank_n = 1'h1;
    tick(3);
    chk(oe, W2);
    load = 1'h0;
    $display("t_shift done");
  endtask
  // stalled chain: buffer fills, extra falls lost; then pad fault
  task automatic t_hold();
    ssd_ctrl_inst.power_up();
    hold = 1'h1;
    ssd_ctrl_inst.send(64'h0, 10);
    chk(64'(rdy), 64'h0);
    hold = 1'h0;
    tick(20);
    chk(64'(rdy), 64'h1);
    chk(64'(sdo), 64'(W2[55]));
    fault = 1'h1;
    tick(3);
    chk(64'(mm), 64'h1);
    fault = 1'h0;
    tick(3);
    chk(64'(mm), 64'h0);
    ssd_ctrl_inst.power_down();
    $display("t_hold done");
  endtask
  initial
  begin
    tick(3);
    i_rst = 1'h0;
    tick(2);
    t_load();
    t_pol();
    t_shift();
    t_hold();
    conclude();
  end
endmodule
